// >>> logic/chs_event_status.sv
`default_nettype none

module chs_event_status
    import chs_pkg::*;
#(
    parameter int unsigned ADDR_W = 7  // Byte address width
)
(
    input  wire logic              CLK,              // Function clock
    input  wire logic              RST_B,            // Asynchronous reset
    input  wire logic              CE,               // Clock enable
    input  wire logic [ADDR_W-1:0] AVS_ADDRESS,      // Byte address
    input  wire logic              AVS_READ,         // Read request
    input  wire logic              AVS_WRITE,        // Write request
    input  wire logic [31:0]       AVS_WRITEDATA,    // Write data
    input  wire logic [3:0]        AVS_BYTEENABLE,   // Write byte lanes
    output logic [31:0]            AVS_READDATA,     // Read data
    output logic                   AVS_WAITREQUEST,  // Bus stall
    input  wire logic              DAT3_PIN,         // Card DAT3 pin level
    input  wire chs_event_s        EVENTS,           // Engine event strobes
    input  wire chs_cmd_s          CMD,              // Command issue strobe
    input  wire logic              XFER_ACTIVE,      // Block transfer running
    output logic                   IRQ,              // Interrupt request pulse
    output logic                   DATA_PATH_RESET,  // Data logic held in reset
    output logic                   DATA_HOLD         // Data path waits for busy
);

    // Parameter range check
    if (ADDR_W < CHS_MIN_ADDR_W || ADDR_W > CHS_MAX_ADDR_W) begin : g_addr_chk
        $error("chs_event_status: ADDR_W out of range");
    end

    // Register state and its next value
    chs_state_s  st;             // Current state
    chs_state_s  next_st;        // Next state

    // Combinational helpers
    logic        req;            // Any bus request
    logic        acc;            // Request accepted this edge
    logic        adv;            // State may advance
    logic [15:0] addr;           // Widened byte address
    logic        data_clear_option;           // Command with data clear
    logic        rise;           // Synced pin rising
    logic        fall;           // Synced pin falling
    logic        edge_hit;       // Selected edge seen
    logic        data_done_ok;   // Data done allowed to set
    logic [31:0] set_vec;        // Flag set requests
    logic [31:0] clr_vec;        // Flag clear requests
    logic [31:0] rising;         // Enabled flag transitions
    logic [31:0] wr_word;        // Merged write value

    // Address match against a register offset
    function automatic logic chs_hit(input logic [15:0] a, input logic [15:0] off);
        chs_hit = (a == off);
    endfunction : chs_hit

    // Byte lane merge of write data
    function automatic logic [31:0] chs_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        chs_merge = res;
    endfunction : chs_merge

    // Control register as read back
    function automatic logic [31:0] chs_ctrl_word(input chs_state_s s);
        logic [31:0] w;
        w = '0;
        w[CHS_BIT_DRST] = s.dreset;
        w[CHS_EDGE_MSB:CHS_EDGE_LSB] = s.edge_sel;
        chs_ctrl_word = w;
    endfunction : chs_ctrl_word

    // Read multiplexer, unmapped reads return zero
    function automatic logic [31:0] chs_read(input logic [15:0] a, input chs_state_s s);
        logic [31:0] r;
        r = '0;
        if (chs_hit(a, CHS_OFF_CTRL)) begin
            r = chs_ctrl_word(s);
        end else if (chs_hit(a, CHS_OFF_STATUS)) begin
            r = s.status & CHS_FLAG_MASK;
        end else if (chs_hit(a, CHS_OFF_MASK)) begin
            r = s.mask & CHS_FLAG_MASK;
        end
        chs_read = r;
    endfunction : chs_read

    // Next-state logic
    always_comb begin
        next_st = st;
        addr    = 16'(AVS_ADDRESS);
        req     = AVS_READ | AVS_WRITE;
        acc     = req & ~st.wait_req;
        adv     = CE | ~st.wait_req;
        data_clear_option    = CMD.issue & CMD.data_clear;
        wr_word = '0;

        // Bus handshake: one wait cycle, then accept
        next_st.wait_req = ~(req & st.wait_req);
        if (req && st.wait_req && AVS_READ) begin
            next_st.rdata = chs_read(addr, st);  // Snapshot returned at accept
        end

        // Two-stage pin synchroniser, then delayed copy
        next_st.dat3_meta = DAT3_PIN;
        next_st.dat3_sync = st.dat3_meta;
        next_st.dat3_prev = st.dat3_sync;
        rise = st.dat3_sync & ~st.dat3_prev;
        fall = ~st.dat3_sync & st.dat3_prev;

        // Edge select decode
        unique case (st.edge_sel)
            CHS_EDGE_OFF:  edge_hit = 1'b0;
            CHS_EDGE_RISE: edge_hit = rise;
            CHS_EDGE_FALL: edge_hit = fall;
            CHS_EDGE_BOTH: edge_hit = rise | fall;
        endcase

        // Data done only once transfer done is seen
        data_done_ok = EVENTS.data_done & (st.xfer_pend | EVENTS.xfer_done);

        // Flag set sources; command events ignore data reset
        set_vec = '0;
        set_vec[CHS_BIT_CMD_DONE]  = EVENTS.cmd_done;
        set_vec[CHS_BIT_BUSY_DONE] = EVENTS.busy_done;
        set_vec[CHS_BIT_RSP_TOUT]  = EVENTS.resp_timeout;
        set_vec[CHS_BIT_RD_TOUT]   = EVENTS.read_timeout;
        set_vec[CHS_BIT_RSP_CRC]   = EVENTS.resp_crc;
        set_vec[CHS_BIT_RD_CRC]    = EVENTS.read_crc;
        set_vec[CHS_BIT_WR_CRC]    = EVENTS.write_crc;
        set_vec[CHS_BIT_XFER_DONE] = EVENTS.xfer_done & ~st.dreset;
        set_vec[CHS_BIT_DATA_DONE] = data_done_ok & ~st.dreset;
        set_vec[CHS_BIT_EDGE]      = edge_hit;
        set_vec[CHS_BIT_RX_READY]  = EVENTS.rx_arrived & ~st.dreset;
        // Transmit ready forced by reset, clear, write or word sent
        set_vec[CHS_BIT_TX_READY]  = EVENTS.tx_sent | EVENTS.tx_write
                                   | data_clear_option | st.dreset;

        // Flag clear sources
        clr_vec = '0;
        if (acc && AVS_READ && chs_hit(addr, CHS_OFF_STATUS)) begin
            clr_vec = st.rdata & CHS_RC_MASK;  // Clear only what was returned
        end
        clr_vec[CHS_BIT_RX_READY] = EVENTS.rx_read | data_clear_option | st.dreset;
        clr_vec[CHS_BIT_TX_READY] = EVENTS.tx_fill;

        // Set wins over clear; reserved bits forced low
        next_st.status = ((st.status & ~clr_vec) | set_vec) & CHS_FLAG_MASK;

        // Interrupt on enabled zero-to-one transitions, one line
        rising      = next_st.status & ~st.status & st.mask;
        next_st.irq = |rising;

        // Transfer done pending until data done
        next_st.xfer_pend = (st.xfer_pend | EVENTS.xfer_done) & ~data_done_ok & ~st.dreset;

        // Busy-expected command during transfer holds data path
        if (CMD.issue && CMD.busy_expected && XFER_ACTIVE) begin
            next_st.hold = 1'b1;
        end else if (EVENTS.busy_done || st.dreset) begin
            next_st.hold = 1'b0;
        end

        // Register writes at accept
        if (acc && AVS_WRITE) begin
            if (chs_hit(addr, CHS_OFF_CTRL)) begin
                wr_word          = chs_merge(chs_ctrl_word(st), AVS_WRITEDATA, AVS_BYTEENABLE);
                next_st.dreset   = wr_word[CHS_BIT_DRST];
                next_st.edge_sel = wr_word[CHS_EDGE_MSB:CHS_EDGE_LSB];
            end else if (chs_hit(addr, CHS_OFF_MASK)) begin
                wr_word      = chs_merge(st.mask, AVS_WRITEDATA, AVS_BYTEENABLE);
                next_st.mask = wr_word & CHS_FLAG_MASK;
            end
        end
    end

    // State register; a granted bus cycle completes even with CE low
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= CHS_STATE_RST;
        end else if (adv) begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign AVS_READDATA    = st.rdata;
    assign AVS_WAITREQUEST = st.wait_req;
    assign IRQ             = st.irq;
    assign DATA_PATH_RESET = st.dreset;
    assign DATA_HOLD       = st.hold;

    // Enabled rising flag gives interrupt pulse
    irq_rise_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && (|rising)) |=> IRQ)
        else $error("interrupt missing after enabled flag rise");

    // No flag interrupts while every enable is clear
    irq_masked_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && st.mask == '0) |=> !IRQ)
        else $error("interrupt with all enables clear");

    // Status read clears the returned clear-on-read flags
    read_clear_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (acc && AVS_READ && chs_hit(addr, CHS_OFF_STATUS) && (set_vec & CHS_RC_MASK) == '0)
        |=> (st.status & $past(st.rdata) & CHS_RC_MASK) == '0)
        else $error("status flags survived a read");

    // Receive ready cleared by its clear sources
    rx_clear_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && (EVENTS.rx_read || data_clear_option || st.dreset) && !(EVENTS.rx_arrived && !st.dreset))
        |=> !st.status[CHS_BIT_RX_READY])
        else $error("receive ready not cleared");

    // Receive ready set on arrival
    rx_set_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.rx_arrived && !st.dreset) |=> st.status[CHS_BIT_RX_READY])
        else $error("receive ready not set");

    // Transmit ready forced by reset, clear or write
    tx_force_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && (EVENTS.tx_write || data_clear_option || st.dreset)) |=> st.status[CHS_BIT_TX_READY])
        else $error("transmit ready not forced");

    // Transfer done sets after last byte
    xfer_done_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.xfer_done && !st.dreset) |=> st.status[CHS_BIT_XFER_DONE])
        else $error("transfer done flag missing");

    // Data done refused without prior transfer done
    data_order_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.data_done && !st.xfer_pend && !EVENTS.xfer_done
         && !st.status[CHS_BIT_DATA_DONE]) |=> !st.status[CHS_BIT_DATA_DONE])
        else $error("data done before transfer done");

    // Selected falling card edge sets its flag
    edge_flag_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && st.edge_sel == CHS_EDGE_FALL && fall) |=> st.status[CHS_BIT_EDGE])
        else $error("card edge flag missing");

    // Reserved bits stay zero
    reserved_zero_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (st.status & ~CHS_FLAG_MASK) == '0 && (st.mask & ~CHS_FLAG_MASK) == '0)
        else $error("reserved status bits set");

    // Busy-expected command in transfer holds data path
    busy_hold_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && CMD.issue && CMD.busy_expected && XFER_ACTIVE) |=> DATA_HOLD)
        else $error("data path not held for busy");

    // Command done independent of data reset
    cmd_indep_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.cmd_done && st.dreset) |=> st.status[CHS_BIT_CMD_DONE])
        else $error("command flag blocked by data reset");

    // Bus answers one cycle after a request is seen
    bus_answer_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer timing wrong");

    // Transmit fill with no set source drops transmit ready
    tx_clear_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.tx_fill && !(EVENTS.tx_sent || EVENTS.tx_write || data_clear_option || st.dreset))
        |=> !st.status[CHS_BIT_TX_READY])
        else $error("transmit ready not cleared");

    // Rising card edge sets its flag
    edge_rise_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && st.edge_sel == CHS_EDGE_RISE && rise) |=> st.status[CHS_BIT_EDGE])
        else $error("rising card edge missed");

    // Disabled edge select never sets the flag
    edge_off_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && st.edge_sel == CHS_EDGE_OFF && !st.status[CHS_BIT_EDGE])
        |=> !st.status[CHS_BIT_EDGE])
        else $error("card edge flag with detection off");

    // Each CRC error strobe sets its own flag
    crc_flags_a : assert property (@(posedge CLK) disable iff (!RST_B)
        adv |=> (st.status[CHS_BIT_RSP_CRC] || !$past(EVENTS.resp_crc))
            && (st.status[CHS_BIT_RD_CRC] || !$past(EVENTS.read_crc))
            && (st.status[CHS_BIT_WR_CRC] || !$past(EVENTS.write_crc)))
        else $error("CRC error flag missing");

    // Response wait expiry sets its flag
    rsp_tout_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.resp_timeout) |=> st.status[CHS_BIT_RSP_TOUT])
        else $error("response timeout flag missing");

    // Read data wait expiry sets its flag
    rd_tout_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.read_timeout) |=> st.status[CHS_BIT_RD_TOUT])
        else $error("read timeout flag missing");

    // Sent or answered command sets its flag
    cmd_done_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.cmd_done) |=> st.status[CHS_BIT_CMD_DONE])
        else $error("command done flag missing");

    // Busy release sets its flag
    busy_done_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && EVENTS.busy_done) |=> st.status[CHS_BIT_BUSY_DONE])
        else $error("busy done flag missing");

    // Busy end or data reset releases the hold
    hold_release_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (adv && DATA_HOLD && (EVENTS.busy_done || st.dreset)
         && !(CMD.issue && CMD.busy_expected && XFER_ACTIVE)) |=> !DATA_HOLD)
        else $error("data path hold not released");

    // Control write sets the data path reset level
    dreset_write_a : assert property (@(posedge CLK) disable iff (!RST_B)
        (acc && AVS_WRITE && chs_hit(addr, CHS_OFF_CTRL) && AVS_BYTEENABLE[0])
        |=> DATA_PATH_RESET == $past(AVS_WRITEDATA[CHS_BIT_DRST]))
        else $error("data path reset not written");

endmodule : chs_event_status

`default_nettype wire

// >>> logic/chs_pkg.sv
// Operation
// - Enabled rising status flag raises CPU interrupt
// - Status read clears the returned clear-on-read flags
// - Ready flags read-only, event driven, reset default
// - Receive ready sets when new word arrives
// - Receive ready clears on reset, clear, read
// - Transmit ready forced on reset, clear, write
// - Transmit ready means register accepts new word
// - Transfer done sets after last byte
// - Data done follows transfer done, after CRC
// - Card edge flag sets on selected edge
// - Response, read, write CRC errors flagged
// - Response timeout flag on expired response wait
// - Read timeout flag on expired data wait
// - Command done on sent or answered command
// - Busy done on release or missing busy
// - Command path independent of data path
// - Busy-expected command during transfer holds data
// - Unused flag and reserved bits read zero
// - Mask bit per flag gates its interrupt
// - Data path reset bit holds data logic
// - Edge select: off, rise, fall, both
`default_nettype none

package chs_pkg;

    // Register byte offsets
    localparam logic [15:0] CHS_OFF_CTRL   = 16'h0000;  // Host control register
    localparam logic [15:0] CHS_OFF_STATUS = 16'h0008;  // Event status register
    localparam logic [15:0] CHS_OFF_MASK   = 16'h0010;  // Event interrupt mask register
    localparam int unsigned CHS_MIN_ADDR_W = 5;         // Address bits needed for the map
    localparam int unsigned CHS_MAX_ADDR_W = 16;        // Widest address decoded

    // Status flag positions
    localparam int unsigned CHS_BIT_DATA_DONE  = 0;     // Data done
    localparam int unsigned CHS_BIT_BUSY_DONE  = 1;     // Busy done
    localparam int unsigned CHS_BIT_CMD_DONE   = 2;     // Command done
    localparam int unsigned CHS_BIT_RD_TOUT    = 3;     // Read timeout
    localparam int unsigned CHS_BIT_RSP_TOUT   = 4;     // Response timeout
    localparam int unsigned CHS_BIT_WR_CRC     = 5;     // Write CRC error
    localparam int unsigned CHS_BIT_RD_CRC     = 6;     // Read CRC error
    localparam int unsigned CHS_BIT_RSP_CRC    = 7;     // Response CRC error
    localparam int unsigned CHS_BIT_TX_READY   = 9;     // Transmit ready
    localparam int unsigned CHS_BIT_RX_READY   = 10;    // Receive ready
    localparam int unsigned CHS_BIT_EDGE       = 11;    // Card detect edge
    localparam int unsigned CHS_BIT_XFER_DONE  = 12;    // Transfer done

    // Status and mask field masks
    localparam logic [31:0] CHS_FLAG_MASK = 32'h0000_1EFF;  // Implemented flags
    localparam logic [31:0] CHS_RC_MASK   = 32'h0000_18FF;  // Clear-on-read flags

    // Control register fields
    localparam int unsigned CHS_BIT_DRST   = 0;         // Data path reset
    localparam int unsigned CHS_EDGE_LSB   = 6;         // Edge select low bit
    localparam int unsigned CHS_EDGE_MSB   = 7;         // Edge select high bit

    // Edge select encodings
    localparam logic [1:0] CHS_EDGE_OFF  = 2'h0;        // Detection disabled
    localparam logic [1:0] CHS_EDGE_RISE = 2'h1;        // Rising edges
    localparam logic [1:0] CHS_EDGE_FALL = 2'h2;        // Falling edges
    localparam logic [1:0] CHS_EDGE_BOTH = 2'h3;        // Both edges

    // Event strobes from command and data engines
    typedef struct packed {
        logic cmd_done;      // Command sent or response received
        logic busy_done;     // Busy released or not seen
        logic resp_timeout;  // Response wait expired
        logic read_timeout;  // Read data wait expired
        logic resp_crc;      // Response CRC error
        logic read_crc;      // Read data CRC error
        logic write_crc;     // Write data CRC error
        logic xfer_done;     // Last byte of transfer done
        logic data_done;     // CRC and programming finished
        logic rx_arrived;    // New word in receive register
        logic rx_read;       // Receive register read
        logic tx_write;      // Transmit register written
        logic tx_fill;       // Transmit register occupied
        logic tx_sent;       // Transmit word shifted out
    } chs_event_s;

    // Command issue strobe with options
    typedef struct packed {
        logic issue;          // Command issued this cycle
        logic data_clear;     // Data clear option
        logic busy_expected;  // Busy expected option
    } chs_cmd_s;

    // Whole block state
    typedef struct packed {
        logic        dat3_meta;   // Pin sync stage one
        logic        dat3_sync;   // Pin sync stage two
        logic        dat3_prev;   // Delayed synced level
        logic        dreset;      // Data path reset control
        logic [1:0]  edge_sel;    // Edge select field
        logic [31:0] status;      // Event status flags
        logic [31:0] mask;        // Interrupt enables
        logic        xfer_pend;   // Transfer done awaiting data done
        logic        hold;        // Data path held for busy
        logic        irq;         // Interrupt pulse
        logic        wait_req;    // Bus wait request
        logic [31:0] rdata;       // Bus read data
    } chs_state_s;

    // Reset state
    localparam chs_state_s CHS_STATE_RST = '{wait_req: 1'b1, default: '0};

endpackage : chs_pkg

`default_nettype wire

// >>> dv/chs_bus_master.sv
`default_nettype none

module chs_bus_master #(
    parameter int unsigned ADDR_W = 7  // Byte address width
) (
    input  wire logic              clk,       // Bus clock
    output var  logic [ADDR_W-1:0] addr,      // Byte address
    output var  logic              rd,        // Read request
    output var  logic              wr,        // Write request
    output var  logic [31:0]       wdata,     // Write data
    input  wire logic [31:0]       rdata,     // Read data
    input  wire logic              wait_req   // Slave stall
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus from time zero
    initial begin
        addr  = '0;
        rd    = 1'b0;
        wr    = 1'b0;
        wdata = '0;
    end

    // One word access, held until stall is seen low at an edge
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        do @(posedge clk); while (wait_req !== 1'b0);
        q = rdata;  // Read data taken at the accepting edge
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : acc
endmodule : chs_bus_master

`default_nettype wire

// >>> dv/tb_card_host_event_status.sv
`default_nettype none

module tb_card_host_event_status
    import chs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // One table case: strobe, mask, status and interrupt expected
    typedef struct packed {
        logic [13:0] ev;   // Event strobes
        logic [15:0] msk;  // Mask written first
        logic [15:0] st;   // Status expected
        logic        irq;  // Interrupt expected
    } chs_row_s;

    logic        clk;        // Function clock
    logic        rst_b;      // Reset, active low
    logic [6:0]  addr;       // Bus address
    logic        rd;         // Bus read
    logic        wr;         // Bus write
    logic [31:0] wdata;      // Bus write data
    logic [31:0] rdata;      // Bus read data
    logic        wait_req;   // Bus stall
    logic        dat3;       // Card pin
    chs_event_s  events;     // Engine strobes
    chs_cmd_s    cmd;        // Command strobe
    logic        xfer;       // Transfer running
    logic        irq;        // Interrupt pulse
    logic        dpr;        // Data path reset
    logic        hold;       // Data hold
    logic        ce;         // Clock enable
    logic [3:0]  be;         // Write byte lanes
    int          err_count;  // Mismatches
    int          tests_run;  // Comparisons
    int          cyc;        // Cycle counter
    logic [31:0] q;          // Read result
    logic        iq;         // Sampled interrupt
    chs_row_s    rows [17] = '{
        '{14'h2000, 16'h0004, 16'h0004, 1'b1}, '{14'h1000, 16'h0000, 16'h0002, 1'b0},
        '{14'h0800, 16'h0010, 16'h0010, 1'b1}, '{14'h0400, 16'h0008, 16'h0008, 1'b1},
        '{14'h0200, 16'h0080, 16'h0080, 1'b1}, '{14'h0100, 16'h0040, 16'h0040, 1'b1},
        '{14'h0080, 16'h0020, 16'h0020, 1'b1}, '{14'h0020, 16'h0001, 16'h0000, 1'b0},
        '{14'h0040, 16'h1000, 16'h1000, 1'b1}, '{14'h0020, 16'h0001, 16'h0001, 1'b1},
        '{14'h0010, 16'h0400, 16'h0400, 1'b1}, '{14'h0008, 16'h0400, 16'h0000, 1'b0},
        '{14'h0004, 16'h0200, 16'h0200, 1'b1}, '{14'h0002, 16'h0200, 16'h0000, 1'b0},
        '{14'h0001, 16'h0200, 16'h0200, 1'b1}, '{14'h0002, 16'h0000, 16'h0000, 1'b0},
        '{14'h2200, 16'h0080, 16'h0084, 1'b1}};

    chs_event_status dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .DAT3_PIN(dat3), .EVENTS(events),
        .CMD(cmd), .XFER_ACTIVE(xfer), .IRQ(irq), .DATA_PATH_RESET(dpr), .DATA_HOLD(hold));

    chs_bus_master #(.ADDR_W(7)) bm (.clk(clk), .addr(addr), .rd(rd), .wr(wr),
        .wdata(wdata), .rdata(rdata), .wait_req(wait_req));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One-cycle strobe, then interrupt sampled in the following cycle
    task automatic pulse(input logic [13:0] e, input logic [2:0] c);
        @(posedge clk);
        events <= e;
        cmd    <= c;
        @(posedge clk);
        events <= '0;
        cmd    <= '0;
        @(posedge clk);
        iq = irq;
    endtask : pulse

    // Every register and two unmapped places read zero, outputs idle
    task automatic zeros();
        chk("outs", {29'h0, irq, dpr, hold}, '0);
        for (int a = 0; a < 20; a += 4) begin
            bm.acc(1'b0, 7'(a), '0, q);
            chk("rst_read", q, '0);
        end
    endtask : zeros

    // Closing report
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        rst_b = 1'b0;
        dat3 = 1'b0;
        events = '0;
        cmd = '0;
        xfer = 1'b0;
        ce = 1'b1;
        be = 4'hF;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        zeros();
        // Status write is ignored
        bm.acc(1'b1, 7'h08, 32'hFFFF_FFFF, q);
        bm.acc(1'b0, 7'h08, '0, q);
        chk("status_ro", q, '0);
        // Table of single events, last row two at once
        foreach (rows[i]) begin
            bm.acc(1'b1, 7'h10, {16'h0000, rows[i].msk}, q);
            pulse(rows[i].ev, 3'h0);
            chk("irq", {31'h0, iq}, {31'h0, rows[i].irq});
            bm.acc(1'b0, 7'h08, '0, q);
            chk("status", q, {16'h0000, rows[i].st});
            bm.acc(1'b0, 7'h08, '0, q);
            chk("status_rc", q, {16'h0000, rows[i].st} & ~CHS_RC_MASK);
        end
        bm.acc(1'b0, 7'h10, '0, q);
        chk("mask_rw", q, 32'h0000_0080);
        // Single byte lane write keeps the other lanes
        be <= 4'h2;
        bm.acc(1'b1, 7'h10, 32'hFFFF_FFFF, q);
        be <= 4'hF;
        bm.acc(1'b0, 7'h10, '0, q);
        chk("mask_lane", q, 32'h0000_1E80);
        // Data path held: arrivals ignored, transmit ready forced
        bm.acc(1'b1, 7'h00, 32'h0000_0001, q);
        repeat (2) @(posedge clk);
        chk("dpr_on", {31'h0, dpr}, 32'h0000_0001);
        pulse(14'h2050, 3'h0);
        bm.acc(1'b0, 7'h08, '0, q);
        chk("status_dpr", q, 32'h0000_0204);
        bm.acc(1'b1, 7'h00, 32'h0000_0000, q);
        repeat (2) @(posedge clk);
        chk("dpr_off", {31'h0, dpr}, '0);
        // Clear command with a fill in the same cycle
        pulse(14'h0010, 3'h0);
        pulse(14'h0002, 3'h6);
        bm.acc(1'b0, 7'h08, '0, q);
        chk("status_clr", q, 32'h0000_0200);
        // Every edge select code, rise then fall
        for (int s = 0; s < 4; s++) begin
            bm.acc(1'b1, 7'h00, 32'(s) << 6, q);
            dat3 <= 1'b1;
            repeat (6) @(posedge clk);
            bm.acc(1'b0, 7'h08, '0, q);
            chk("edge_rise", q & 32'h0000_0800, {20'h0, s[0], 11'h0});
            dat3 <= 1'b0;
            repeat (6) @(posedge clk);
            bm.acc(1'b0, 7'h08, '0, q);
            chk("edge_fall", q & 32'h0000_0800, {20'h0, s[1], 11'h0});
        end
        bm.acc(1'b0, 7'h00, '0, q);
        chk("ctrl_rw", q, 32'h0000_00C0);
        // Event while clock enable is low is not taken
        ce <= 1'b0;
        pulse(14'h0200, 3'h0);
        ce <= 1'b1;
        bm.acc(1'b0, 7'h08, '0, q);
        chk("ce_freeze", q & 32'h0000_0080, '0);
        // Commands during a transfer
        xfer <= 1'b1;
        pulse(14'h0000, 3'h4);
        chk("hold_plain", {31'h0, hold}, '0);
        pulse(14'h0000, 3'h5);
        chk("hold_set", {31'h0, hold}, 32'h0000_0001);
        pulse(14'h2000, 3'h0);
        chk("hold_keep", {31'h0, hold}, 32'h0000_0001);
        bm.acc(1'b0, 7'h08, '0, q);
        chk("cmd_in_xfer", q & 32'h0000_0004, 32'h0000_0004);
        pulse(14'h1000, 3'h0);
        chk("hold_done", {31'h0, hold}, '0);
        xfer <= 1'b0;
        // Second reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        zeros();
        give_verdict();
    end
endmodule : tb_card_host_event_status

`default_nettype wire
